/* File: inc/general_timer_one_pkg.sv */
// constants, types and helpers shared by the general timer one design
// Operation
// - a 16-bit counter serves as clock time base, interval timer or event counter
// - the count clock may come from a slow 32 kHz oscillator on the external input
// - asynchronous counter mode counts the external input without the after-prescaler resync
// - with sync selected, the prescaler output is resynchronised to the device clock
// - timer and gated modes count the instruction clock; counter modes the external input
// - mode comes from clock source bit 1, sync bit 2 and gate bit 6
// - timer_run bit 15 set starts the counter, cleared stops it
// - idle_halt_select bit 13 set stops the counter while the device idles
// - gate bit 6 enables gated accumulation on internal clock, ignored on external
// - prescale_select bits 5-4: 11 1:256, 10 1:64, 01 1:8, 00 1:1
// - sync bit 2 selects external input synchronisation, ignored on internal clock
// - clock source bit 1 set counts external rising edges, cleared uses instruction clock
`default_nettype none
package general_timer_one_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // register map
  localparam logic [11:0] ADDR_CONTROL = 12'h000;
  localparam logic [11:0] ADDR_COUNT = 12'h004;

  ////////////////////////////////////////////////////////////////////////////////
  // control word fields
  localparam int RUN_BIT = 15;
  localparam int IDLE_HALT_BIT = 13;
  localparam int GATE_BIT = 6;
  localparam int PRESCALE_LSB = 4;
  localparam int PRESCALE_MSB = 5;
  localparam int SYNC_BIT = 2;
  localparam int SOURCE_BIT = 1;
  localparam logic [15:0] CONTROL_MASK = 16'hA076;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;

  localparam logic [1:0] PRESCALE_1 = 2'h0;
  localparam logic [1:0] PRESCALE_8 = 2'h1;
  localparam logic [1:0] PRESCALE_64 = 2'h2;
  localparam logic [1:0] PRESCALE_256 = 2'h3;

  // terminal values of the prescale divider, ratio minus one
  localparam logic [7:0] LIMIT_1 = 8'h00;
  localparam logic [7:0] LIMIT_8 = 8'h07;
  localparam logic [7:0] LIMIT_64 = 8'h3F;
  localparam logic [7:0] LIMIT_256 = 8'hFF;

  typedef enum logic [1:0] {
    MODE_TIMER,
    MODE_GATED,
    MODE_SYNC_COUNT,
    MODE_ASYNC_COUNT
  } mode_e;

  function automatic logic [7:0] prescale_limit(input logic [1:0] sel);
    logic [7:0] lim;
    lim = LIMIT_1;
    unique case (sel)
      PRESCALE_1: lim = LIMIT_1;
      PRESCALE_8: lim = LIMIT_8;
      PRESCALE_64: lim = LIMIT_64;
      PRESCALE_256: lim = LIMIT_256;
    endcase
    return lim;
  endfunction

  function automatic mode_e decode_mode(input logic [15:0] ctrl);
    mode_e m;
    m = MODE_TIMER;
    if (ctrl[SOURCE_BIT]) begin
      m = ctrl[SYNC_BIT] ? MODE_SYNC_COUNT : MODE_ASYNC_COUNT;
    end else begin
      m = ctrl[GATE_BIT] ? MODE_GATED : MODE_TIMER;
    end
    return m;
  endfunction

endpackage
`default_nettype wire

/* File: rtl/general_timer_one.sv */
// general timer one: apb register slave, mode select, prescale and 16-bit counter
`timescale 1ns/10ps
`default_nettype none
module general_timer_one (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_count_input,
  input wire logic gate_input,
  input wire logic device_idle,
  output logic [15:0] count_value,
  output logic count_pulse
);

  ////////////////////////////////////////////////////////////////////////////////
  // apb slave
  logic access_done;
  logic addr_control;
  logic addr_count;
  logic write_control;
  logic write_count;
  logic [15:0] timer_one_control;
  logic [15:0] next_control;
  logic [15:0] next_count_write;

  assign access_done = psel && penable && pready;
  assign addr_control = (paddr == general_timer_one_pkg::ADDR_CONTROL);
  assign addr_count = (paddr == general_timer_one_pkg::ADDR_COUNT);
  assign write_control = access_done && pwrite && addr_control;
  assign write_count = access_done && pwrite && addr_count;

  // one wait state: pready rises the cycle after the access phase opens
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !addr_control && !addr_count;
      if (psel && penable && !pready && !pwrite && addr_control) begin
        prdata <= {16'h0000, timer_one_control};
      end else if (psel && penable && !pready && !pwrite && addr_count) begin
        prdata <= {16'h0000, count_value};
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

  // byte lanes 0 and 1 carry the 16-bit registers; lanes 2 and 3 are dropped
  always_comb begin
    next_control = timer_one_control;
    next_count_write = count_value;
    if (pstrb[0]) begin
      next_control[7:0] = pwdata[7:0];
      next_count_write[7:0] = pwdata[7:0];
    end
    if (pstrb[1]) begin
      next_control[15:8] = pwdata[15:8];
      next_count_write[15:8] = pwdata[15:8];
    end
    next_control = next_control & general_timer_one_pkg::CONTROL_MASK;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_one_control <= general_timer_one_pkg::CONTROL_RESET;
    end else if (write_control) begin
      timer_one_control <= next_control;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // control decode
  logic run;
  logic idle_halt_select;
  logic gate_accumulate_enable;
  logic ext_clock_sync_select;
  logic clock_source_select;
  logic [1:0] prescale_select;
  general_timer_one_pkg::mode_e mode;

  assign run = timer_one_control[general_timer_one_pkg::RUN_BIT];
  assign idle_halt_select = timer_one_control[general_timer_one_pkg::IDLE_HALT_BIT];
  assign gate_accumulate_enable = timer_one_control[general_timer_one_pkg::GATE_BIT];
  assign ext_clock_sync_select = timer_one_control[general_timer_one_pkg::SYNC_BIT];
  assign clock_source_select = timer_one_control[general_timer_one_pkg::SOURCE_BIT];
  assign prescale_select = timer_one_control[general_timer_one_pkg::PRESCALE_MSB:
                                             general_timer_one_pkg::PRESCALE_LSB];
  assign mode = general_timer_one_pkg::decode_mode(timer_one_control);

  ////////////////////////////////////////////////////////////////////////////////
  // pin inputs
  logic ext_level;
  logic ext_rise;
  logic gate_level;

  // a 32 kHz source is far below the sampling rate, so no edge is missed
  pin_level_filter ext_filter (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(external_count_input),
    .level(ext_level),
    .rise(ext_rise)
  );

  pin_level_filter gate_filter (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(gate_input),
    .level(gate_level),
    .rise()
  );

  ////////////////////////////////////////////////////////////////////////////////
  // count clock selection
  logic enabled;
  logic source_tick;
  logic tick_in;
  logic pre_out;

  // idle stops the count only when the halt option is set
  assign enabled = run && !(idle_halt_select && device_idle);

  always_comb begin
    source_tick = 1'b0;
    unique case (mode)
      general_timer_one_pkg::MODE_TIMER: source_tick = 1'b1;
      general_timer_one_pkg::MODE_GATED: source_tick = gate_level;
      general_timer_one_pkg::MODE_SYNC_COUNT: source_tick = ext_rise;
      general_timer_one_pkg::MODE_ASYNC_COUNT: source_tick = ext_rise;
    endcase
  end

  assign tick_in = enabled && source_tick;

  // the divider is cleared while stopped, so a fresh start gives a full period
  tick_prescaler prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .clear(!run),
    .tick_in(tick_in),
    .select(prescale_select),
    .tick_out(pre_out)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // resync after the prescaler
  logic resync_tick;
  logic increment;

  // the resync stage costs one cycle of latency in synchronous counter mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resync_tick <= 1'b0;
    end else begin
      resync_tick <= pre_out && (mode == general_timer_one_pkg::MODE_SYNC_COUNT);
    end
  end

  always_comb begin
    increment = 1'b0;
    unique case (mode)
      general_timer_one_pkg::MODE_SYNC_COUNT: increment = resync_tick && run;
      general_timer_one_pkg::MODE_ASYNC_COUNT: increment = pre_out;
      general_timer_one_pkg::MODE_TIMER: increment = pre_out;
      general_timer_one_pkg::MODE_GATED: increment = pre_out;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // counter
  // a software write wins over an increment in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_value <= general_timer_one_pkg::COUNT_RESET;
    end else if (write_count) begin
      count_value <= next_count_write;
    end else if (increment) begin
      count_value <= count_value + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_pulse <= 1'b0;
    end else begin
      count_pulse <= increment && !write_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ticks taken since the last prescaler output, kept apart from the divider itself
  logic [7:0] ref_ticks;
  logic ref_valid;

  // a ratio change while running leaves the current period unchecked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_ticks <= 8'h00;
      ref_valid <= 1'b1;
    end else if (!run) begin
      ref_ticks <= 8'h00;
      ref_valid <= 1'b1;
    end else if (write_control) begin
      ref_ticks <= 8'h00;
      ref_valid <= 1'b0;
    end else if (pre_out) begin
      ref_ticks <= 8'h00;
      ref_valid <= 1'b1;
    end else if (tick_in) begin
      ref_ticks <= ref_ticks + 8'h01;
    end
  end

  a_prescale_ratio: assert property (
    (pre_out && ref_valid)
      |-> ref_ticks == general_timer_one_pkg::prescale_limit(prescale_select))
    else $error("prescaler fired before its ratio was reached");

  a_prescale_not_late: assert property (
    (tick_in && ref_valid
      && ref_ticks == general_timer_one_pkg::prescale_limit(prescale_select))
      |-> pre_out)
    else $error("prescaler missed the tick that completes its ratio");

  a_timer_every_cycle: assert property (
    (mode == general_timer_one_pkg::MODE_TIMER && enabled) |-> tick_in)
    else $error("timer mode skipped an instruction clock tick");

  a_gate_passes: assert property (
    (mode == general_timer_one_pkg::MODE_GATED && gate_level && enabled) |-> tick_in)
    else $error("gated mode did not tick with gate high");

  a_pulse_follows: assert property (
    (increment && !write_count) |=> count_pulse)
    else $error("count pulse missing after an increment");

  a_pulse_needs_count: assert property (
    count_pulse |-> $past(increment))
    else $error("count pulse without an increment");

  a_control_read_back: assert property (
    (pready && psel && !pwrite && addr_control) |-> prdata == {16'h0000, timer_one_control})
    else $error("control read returned a wrong word");

  a_reserved_reads_zero: assert property (
    (timer_one_control & ~general_timer_one_pkg::CONTROL_MASK) == 16'h0000)
    else $error("unimplemented control bit is set");

  a_stopped_holds: assert property (
    (!run && !write_count) |=> $stable(count_value))
    else $error("counter moved while stopped");

  a_idle_halt_holds: assert property (
    (run && idle_halt_select && device_idle && !write_count && !resync_tick)
      |=> $stable(count_value))
    else $error("counter moved during idle with halt selected");

  a_idle_keeps_running: assert property (
    (mode == general_timer_one_pkg::MODE_TIMER && run && !idle_halt_select
      && prescale_select == general_timer_one_pkg::PRESCALE_1 && !write_count)
      |=> count_value == $past(count_value) + 16'h0001)
    else $error("timer at 1:1 did not count every cycle");

  a_gate_blocks: assert property (
    (mode == general_timer_one_pkg::MODE_GATED && !gate_level) |-> !tick_in)
    else $error("gated mode ticked with gate low");

  a_gate_ignored_ext: assert property (
    (clock_source_select && gate_accumulate_enable && enabled && ext_rise) |-> tick_in)
    else $error("gate bit affected external clock counting");

  a_prescale_eight: assert property (
    (pre_out && prescale_select == general_timer_one_pkg::PRESCALE_8)
      |=> (!pre_out || prescale_select != general_timer_one_pkg::PRESCALE_8)[*7])
    else $error("1:8 prescaler fired early");

  a_sync_after_prescale: assert property (
    (pre_out && mode == general_timer_one_pkg::MODE_SYNC_COUNT
      && $stable(timer_one_control)) |=> (increment || !run))
    else $error("resynchronised tick did not follow prescaler by one cycle");

  a_async_direct: assert property (
    (mode == general_timer_one_pkg::MODE_ASYNC_COUNT && pre_out) |-> increment)
    else $error("asynchronous counter did not count prescaler tick");

  a_ext_edge_only: assert property (
    (clock_source_select && !ext_rise) |-> !tick_in)
    else $error("external mode ticked without an input edge");

  a_increment_by_one: assert property (
    (increment && !write_count) |=> count_value == $past(count_value) + 16'h0001)
    else $error("counter did not advance by one");

  c_wrap: cover property (increment && count_value == 16'hFFFF);
  c_sync_count: cover property (mode == general_timer_one_pkg::MODE_SYNC_COUNT && increment);
  c_gated_count: cover property (mode == general_timer_one_pkg::MODE_GATED && increment);
  c_idle_halt: cover property (run && idle_halt_select && device_idle);
  c_prescale_256: cover property (
    pre_out && prescale_select == general_timer_one_pkg::PRESCALE_256);

endmodule // general_timer_one
`default_nettype wire

/* File: rtl/pin_level_filter.sv */
// three-stage pin synchroniser with agreement filter and rising-edge pulse
`timescale 1ns/10ps
`default_nettype none
module pin_level_filter (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin_in,
  output logic level,
  output logic rise
);

  logic stage1;
  logic stage2;
  logic stage3;

  // stage1 feeds only stage2; metastability settles before any decision
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // a change counts only once the second and third stages agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level <= 1'b0;
      rise <= 1'b0;
    end else begin
      if (stage2 == stage3) begin
        level <= stage3;
      end
      rise <= (stage2 == stage3) && stage3 && !level;
    end
  end

endmodule // pin_level_filter
`default_nettype wire

/* File: rtl/tick_prescaler.sv */
// selectable 1/8/64/256 divider of a tick stream
`timescale 1ns/10ps
`default_nettype none
module tick_prescaler (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clear,
  input wire logic tick_in,
  input wire logic [1:0] select,
  output logic tick_out
);

  logic [7:0] div_count;
  logic [7:0] limit;

  assign limit = general_timer_one_pkg::prescale_limit(select);
  // a shrinking ratio mid-count fires at once rather than wrapping through 256
  assign tick_out = tick_in && (div_count >= limit);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_count <= 8'h00;
    end else if (clear) begin
      div_count <= 8'h00;
    end else if (tick_in) begin
      if (div_count >= limit) begin
        div_count <= 8'h00;
      end else begin
        div_count <= div_count + 8'h01;
      end
    end
  end

endmodule // tick_prescaler
`default_nettype wire

/* File: sim/ext_clock_source.sv */
// external count source: bursts of square-wave edges on the count pin
`timescale 1ns/10ps
`default_nettype none
module ext_clock_source (
  input wire logic pclk,
  input wire logic start,
  input wire logic [7:0] n_edges,
  input wire logic [7:0] half_cycles,
  output logic pin,
  output logic busy
);
  int e;
  int h;
  // the pin rests low between bursts, like a gated oscillator that stands still
  initial begin
    pin = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge pclk);
      if (start === 1'b1) begin
        busy <= 1'b1;
        for (e = 0; e < n_edges; e++) begin
          // long half periods stand in for the slow crystal
          for (h = 0; h < half_cycles; h++) @(posedge pclk);
          pin <= 1'b1;
          for (h = 0; h < half_cycles; h++) @(posedge pclk);
          pin <= 1'b0;
        end
        busy <= 1'b0;
      end
    end
  end
endmodule  // ext_clock_source
`default_nettype wire

/* File: sim/tb_general_timer_one.sv */
// testbench for general timer one: register access, modes, prescale and counting
`timescale 1ns/10ps
`default_nettype none
module tb_general_timer_one;
  typedef struct {
    logic [15:0] ctrl;
    logic gate;
    logic idle;
    logic [7:0] edges;
    logic [7:0] half;
    int cycles;
    logic [15:0] lo;
    logic [15:0] hi;
  } row_s;
  // internal rows span about eight cycles of bus latency around the wait
  row_s rows [16] = '{
    '{16'h8000, 1'b0, 1'b0, 8'h00, 8'h00, 40, 16'h002A, 16'h0030},
    '{16'h8010, 1'b0, 1'b0, 8'h00, 8'h00, 160, 16'h0013, 16'h0015},
    '{16'h8020, 1'b0, 1'b0, 8'h00, 8'h00, 640, 16'h0009, 16'h000B},
    '{16'h8030, 1'b0, 1'b0, 8'h00, 8'h00, 1024, 16'h0003, 16'h0005},
    '{16'h0000, 1'b0, 1'b0, 8'h00, 8'h00, 100, 16'h0000, 16'h0000},
    '{16'h8040, 1'b0, 1'b0, 8'h00, 8'h00, 100, 16'h0000, 16'h0000},
    '{16'h8040, 1'b1, 1'b0, 8'h00, 8'h00, 40, 16'h002A, 16'h0030},
    '{16'hA000, 1'b0, 1'b1, 8'h00, 8'h00, 100, 16'h0000, 16'h0000},
    '{16'h8000, 1'b0, 1'b1, 8'h00, 8'h00, 40, 16'h002A, 16'h0030},
    '{16'h8004, 1'b0, 1'b0, 8'h00, 8'h00, 40, 16'h002A, 16'h0030},
    '{16'h8006, 1'b0, 1'b0, 8'h0A, 8'h04, 0, 16'h000A, 16'h000A},
    '{16'h8002, 1'b0, 1'b0, 8'h0A, 8'h04, 0, 16'h000A, 16'h000A},
    '{16'h8016, 1'b0, 1'b0, 8'h10, 8'h04, 0, 16'h0002, 16'h0002},
    '{16'h8046, 1'b0, 1'b0, 8'h0A, 8'h04, 0, 16'h000A, 16'h000A},
    '{16'h8002, 1'b0, 1'b0, 8'h03, 8'h32, 0, 16'h0003, 16'h0003},
    '{16'h8002, 1'b0, 1'b0, 8'h00, 8'h00, 100, 16'h0000, 16'h0000}
  };
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, d, base, n_pulse, n_cycles;
  logic [3:0] pstrb;
  logic ext_pin, gate_input, device_idle, count_pulse, start, busy, err;
  logic [15:0] count_value;
  logic [7:0] n_edges, half_cycles;
  int n_fail, comparisons, i;

  general_timer_one general_timer_one_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .external_count_input(ext_pin),
    .gate_input(gate_input), .device_idle(device_idle), .count_value(count_value),
    .count_pulse(count_pulse));
  ext_clock_source ext_clock_source_i (.pclk(pclk), .start(start), .n_edges(n_edges),
    .half_cycles(half_cycles), .pin(ext_pin), .busy(busy));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic reg_write(input logic [11:0] a, input logic [31:0] wd);
    logic [31:0] rd;
    logic er;
    apb(1'b1, a, wd, rd, er);
  endtask
  task automatic reg_read(input logic [11:0] a, output logic [31:0] rd);
    logic er;
    apb(1'b0, a, 32'h00000000, rd, er);
  endtask
  task automatic check_value(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_range(input logic [15:0] got, input logic [15:0] lo,
                             input logic [15:0] hi);
    comparisons++;
    if ($isunknown(got) || got < lo || got > hi) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask
  task automatic summarize;
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    n_cycles = 32'h00000000;
    n_pulse = 32'h00000000;
  end
  always @(posedge pclk) begin
    n_cycles <= n_cycles + 32'h00000001;
    if (count_pulse === 1'b1) n_pulse <= n_pulse + 32'h00000001;
    // the whole run takes about 3500 cycles, so this leaves ample margin
    if (n_cycles == 32'h00004E20) begin
      n_fail++;
      summarize();
    end
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    pstrb = 4'hF;
    gate_input = 1'b0;
    device_idle = 1'b0;
    start = 1'b0;
    n_edges = 8'h00;
    half_cycles = 8'h00;
    n_fail = 0;
    comparisons = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 16; i++) begin
      gate_input <= rows[i].gate;
      device_idle <= rows[i].idle;
      n_edges <= rows[i].edges;
      half_cycles <= rows[i].half;
      reg_write(general_timer_one_pkg::ADDR_COUNT, 32'h00000000);
      base = n_pulse;
      reg_write(general_timer_one_pkg::ADDR_CONTROL, {16'h0000, rows[i].ctrl});
      reg_read(general_timer_one_pkg::ADDR_CONTROL, d);
      check_value(d, {16'h0000, rows[i].ctrl});
      if (rows[i].edges != 8'h00) begin
        @(posedge pclk);
        start <= 1'b1;
        @(posedge pclk);
        start <= 1'b0;
        repeat (2) @(posedge pclk);
        while (busy === 1'b1) @(posedge pclk);
        // the pin filter needs a few cycles to pass the last edge
        repeat (10) @(posedge pclk);
      end else begin
        repeat (rows[i].cycles) @(posedge pclk);
      end
      reg_write(general_timer_one_pkg::ADDR_CONTROL, 32'h00000000);
      reg_read(general_timer_one_pkg::ADDR_COUNT, d);
      check_range(d[15:0], rows[i].lo, rows[i].hi);
      check_value({16'h0000, count_value}, d);
      check_value(n_pulse - base, d);
      $display("row %0d done", i);
    end
    reg_write(general_timer_one_pkg::ADDR_CONTROL, 32'hFFFFFFFF);
    reg_read(general_timer_one_pkg::ADDR_CONTROL, d);
    check_value(d, 32'h0000A076);
    reg_write(general_timer_one_pkg::ADDR_CONTROL, 32'h00000000);
    apb(1'b0, 12'h008, 32'h00000000, d, err);
    check_value(d, 32'h00000000);
    check_value({31'h00000000, err}, 32'h00000001);
    $display("mask and unmapped test done");
    reg_write(general_timer_one_pkg::ADDR_COUNT, 32'h0000FFFD);
    reg_write(general_timer_one_pkg::ADDR_CONTROL, 32'h00008000);
    repeat (8) @(posedge pclk);
    reg_write(general_timer_one_pkg::ADDR_CONTROL, 32'h00000000);
    @(posedge pclk);
    check_range(count_value, 16'h0001, 16'h000F);
    $display("wrap test done");
    reg_write(general_timer_one_pkg::ADDR_CONTROL, 32'h00008000);
    repeat (5) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    check_value({16'h0000, count_value}, 32'h00000000);
    presetn <= 1'b1;
    reg_read(general_timer_one_pkg::ADDR_CONTROL, d);
    check_value(d, 32'h00000000);
    reg_read(general_timer_one_pkg::ADDR_COUNT, d);
    check_value(d, 32'h00000000);
    $display("mid-run reset test done");
    pstrb <= 4'h2;
    reg_write(general_timer_one_pkg::ADDR_COUNT, 32'h0000ABCD);
    pstrb <= 4'hF;
    reg_read(general_timer_one_pkg::ADDR_COUNT, d);
    check_value(d, 32'h0000AB00);
    $display("byte strobe test done");
    summarize();
  end
endmodule  // tb_general_timer_one
`default_nettype wire
